// ---- adcrt_checker.sv ----
// Purpose: Port assertions of the converter register block.
// Assumes: One clock, ce held high by the bench.
// Notes: Bound to adcrt_top from the testbench file.
`timescale 1ns/1ns
module adcrt_checker #(
  parameter AW = 12,
  parameter NPIN = 8
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire conv_enable,
  input wire conv_start,
  input wire comp_neg_from_mux,
  input wire [NPIN-1:0] pin_digital_disable,
  input wire [NPIN-1:0] pin_raw,
  input wire [NPIN-1:0] pin_read_value
);
  // ----
  // Checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire dis_wr = psel && penable && pwrite && ce && paddr == 12'h1f8;
  bus_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray error");
  read_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits");
  steer_off_a: assert property (comp_neg_from_mux |-> !conv_enable) else $error("steer");
  start_pulse_a: assert property (conv_start |-> conv_enable ##1 !conv_start)
    else $error("start pulse");
  pin_gate_a: assert property ((pin_read_value & pin_digital_disable
    & $past(pin_digital_disable)) == 0) else $error("pin not gated");
  pin_follow_a: assert property ((ce && $stable(pin_raw) && $stable(pin_digital_disable))[*5]
    |-> pin_read_value == (pin_raw & ~pin_digital_disable)) else $error("pin value");
  dis_write_a: assert property (dis_wr |=> pin_digital_disable == $past(pwdata[7:0]))
    else $error("disable write");
  dis_hold_a: assert property (!dis_wr |=> $stable(pin_digital_disable))
    else $error("disable");
  cover property (conv_start);
  cover property (pslverr);
  cover property (comp_neg_from_mux);
endmodule // adcrt_checker

// ---- adcrt_core_model.sv ----
// Purpose: Converter core model answering start pulses.
// Assumes: Same clock as the block.
// Notes: Result is only valid with the done pulse.
`timescale 1ns/1ns
module adcrt_core_model (
  input wire pclk,
  input wire presetn,
  input wire conv_start,
  input wire conv_enable,
  input wire [3:0] dly,
  input wire [9:0] value,
  output reg conv_done,
  output reg [9:0] conv_result
);
  reg [3:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_result <= 10'h3ff;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        cnt <= dly;
      end else if (!conv_enable) begin
        cnt <= 4'h0;
      end else if (cnt == 4'h1) begin
        cnt <= 4'h0;
        conv_done <= 1'b1;
        conv_result <= value;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // adcrt_core_model

// ---- adcrt_regs.vh ----
// Purpose: Register indices, field positions, reset values and codes of the converter block.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
//
// Behaviour
// - After the low result byte is read, the result pair is held until the high byte is read.
// - With left alignment the result sits in bits 15:6 and bits 5:0 read zero.
// - With right alignment, the reset default, the result sits in bits 9:0.
// - Low byte at the base index, high byte one above, both read-only and reset to zero.
// - With steering set and the converter off, the comparator negative input takes the mux.
// - The trigger source field has no effect while auto-triggering is off.
// - With auto-triggering on, a rising edge of the selected flag starts a conversion.
// - Switching from a low source to a high one is an edge that starts an enabled conversion.
// - Switching to free-running mode never makes a trigger event by itself.
// - Codes: free run, comparator, ext int 0, t0 cmp A, t0 ovf, t1 cmp B, t1 ovf, t1 capture.
// - A set disable bit turns off that pin's digital buffer and forces its read value to zero.
// - With auto-triggering on, a positive edge of the selected trigger starts a conversion.
// - The conversion-done flag rises when a conversion ends and the result has been updated; here it also rises when a locked pair keeps the old result.
`ifndef ADCRT_REGS_VH
`define ADCRT_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define ADCRT_IDX_IRQ_STAT 8'h70
`define ADCRT_IDX_IRQ_MASK 8'h71
`define ADCRT_IDX_RES_LOW 8'h78
`define ADCRT_IDX_RES_HIGH 8'h79
`define ADCRT_IDX_CTRL_A 8'h7a
`define ADCRT_IDX_TRIG_MUX 8'h7b
`define ADCRT_IDX_CHAN_SEL 8'h7c
`define ADCRT_IDX_PIN_DIS 8'h7e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCRT_CTRLA_ENABLE 7
`define ADCRT_CTRLA_START 6
`define ADCRT_CTRLA_AUTO 5
`define ADCRT_CTRLA_DONE 4
`define ADCRT_CTRLA_PRESC_LSB 0
`define ADCRT_TRIG_STEER 6
`define ADCRT_TRIG_TSEL_LSB 0
`define ADCRT_CHAN_LEFT 5
`define ADCRT_CHAN_REF_LSB 6
`define ADCRT_CHAN_MUX_LSB 0
`define ADCRT_IRQ_DONE 0
`define ADCRT_IRQ_TRIG 1
`define ADCRT_IRQ_LOST 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCRT_RST_BYTE 8'h00
`define ADCRT_RST_RESULT 10'h000
`define ADCRT_RST_IRQ 3'h0

// ----------------------------------------
// Trigger source codes
// ----------------------------------------
`define ADCRT_TS_FREE 3'h0
`define ADCRT_TS_COMP 3'h1
`define ADCRT_TS_EXT0 3'h2
`define ADCRT_TS_T0_CMPA 3'h3
`define ADCRT_TS_T0_OVF 3'h4
`define ADCRT_TS_T1_CMPB 3'h5
`define ADCRT_TS_T1_OVF 3'h6
`define ADCRT_TS_T1_CAPT 3'h7

`endif

// ---- adcrt_sync.v ----
// Purpose: Two-stage synchroniser for a bus of independent levels.
// Assumes: Each bit is a level that may change at any time.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns

module adcrt_sync #(
  parameter W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end else if (ce) begin
      stage1 <= d;
      stage2 <= stage1;
    end
  end

  assign q = stage2;

endmodule // adcrt_sync

// ---- adcrt_top.v ----
// Purpose: Result pair, auto-trigger selection, comparator steering and pin disables over APB.
// Assumes: The converter core shares pclk; trigger flags and pins are asynchronous.
// Notes: Reads take effect in the setup cycle; pready is high in every access cycle.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "adcrt_regs.vh"

module adcrt_top #(
  parameter AW = 12,
  parameter NPIN = 8
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire conv_enable,
  output reg conv_start,
  input wire conv_done,
  input wire [9:0] conv_result,
  output wire [3:0] channel_select,
  output wire [1:0] reference_select,
  output wire [2:0] prescale_select,
  input wire [6:0] trig_flags,
  output wire comp_neg_from_mux,
  output wire [NPIN-1:0] pin_digital_disable,
  input wire [NPIN-1:0] pin_raw,
  output reg [NPIN-1:0] pin_read_value,
  output wire irq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function reg_hit;
    input [AW-1:0] a;
    input [7:0] idx;
    begin
      reg_hit = (a == {{(AW-10){1'b0}}, idx, 2'b00});
    end
  endfunction

  function [15:0] align16;
    input [9:0] r;
    input left;
    begin
      if (left) begin
        align16 = {r, 6'h00};
      end else begin
        align16 = {6'h00, r};
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg converter_enable;
  reg auto_trigger_enable;
  reg [2:0] presc;
  reg busy;
  reg conversion_done_flag;
  reg comparator_mux_steer;
  reg [2:0] trigger_source_select;
  reg [7:0] channel_select_reg;
  reg [NPIN-1:0] pin_input_disable_reg;
  reg [9:0] result;
  reg result_lock;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg trig_prev;
  reg free_switch;

  wire [6+NPIN:0] sync_q;
  wire [6:0] trig_sync;
  wire [NPIN-1:0] pin_sync;

  adcrt_sync #(
    .W(7 + NPIN)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .d({pin_raw, trig_flags}),
    .q(sync_q)
  );

  assign trig_sync = sync_q[6:0];
  assign pin_sync = sync_q[6+NPIN:7];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire setup_rd = psel & ~penable & ~pwrite;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_stat = reg_hit(paddr, `ADCRT_IDX_IRQ_STAT);
  wire hit_mask = reg_hit(paddr, `ADCRT_IDX_IRQ_MASK);
  wire hit_low = reg_hit(paddr, `ADCRT_IDX_RES_LOW);
  wire hit_high = reg_hit(paddr, `ADCRT_IDX_RES_HIGH);
  wire hit_ctla = reg_hit(paddr, `ADCRT_IDX_CTRL_A);
  wire hit_trig = reg_hit(paddr, `ADCRT_IDX_TRIG_MUX);
  wire hit_chan = reg_hit(paddr, `ADCRT_IDX_CHAN_SEL);
  wire hit_pin = reg_hit(paddr, `ADCRT_IDX_PIN_DIS);
  wire mapped = hit_stat | hit_mask | hit_low | hit_high
                | hit_ctla | hit_trig | hit_chan | hit_pin;
  wire left_align_select = channel_select_reg[`ADCRT_CHAN_LEFT];
  wire [15:0] result_view = align16(result, left_align_select);

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (hit_stat) begin
      rd_byte = {5'h00, irq_stat};
    end else if (hit_mask) begin
      rd_byte = {5'h00, irq_mask};
    end else if (hit_low) begin
      rd_byte = result_view[7:0];
    end else if (hit_high) begin
      rd_byte = result_view[15:8];
    end else if (hit_ctla) begin
      rd_byte = {converter_enable, busy, auto_trigger_enable, conversion_done_flag, 1'b0, presc};
    end else if (hit_trig) begin
      rd_byte = {1'b0, comparator_mux_steer, 3'h0, trigger_source_select};
    end else if (hit_chan) begin
      rd_byte = channel_select_reg;
    end else if (hit_pin) begin
      rd_byte = pin_input_disable_reg;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && setup_rd) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------
  // Trigger selection and edge
  // ----------------------------------------
  reg trig_now;

  always @* begin
    case (trigger_source_select)
      `ADCRT_TS_FREE: trig_now = conversion_done_flag;
      `ADCRT_TS_COMP: trig_now = trig_sync[0];
      `ADCRT_TS_EXT0: trig_now = trig_sync[1];
      `ADCRT_TS_T0_CMPA: trig_now = trig_sync[2];
      `ADCRT_TS_T0_OVF: trig_now = trig_sync[3];
      `ADCRT_TS_T1_CMPB: trig_now = trig_sync[4];
      `ADCRT_TS_T1_OVF: trig_now = trig_sync[5];
      `ADCRT_TS_T1_CAPT: trig_now = trig_sync[6];
      default: trig_now = 1'b0;
    endcase
  end

  // A switch into free running masks the one edge it could fake.
  wire trig_edge = trig_now & ~trig_prev & ~free_switch;
  wire auto_fire = auto_trigger_enable & trig_edge;

  wire [2:0] wr_tsel = pwdata[`ADCRT_TRIG_TSEL_LSB+2:`ADCRT_TRIG_TSEL_LSB];
  wire ctla_wr = wr & hit_ctla;
  wire sw_start = ctla_wr & pwdata[`ADCRT_CTRLA_START];
  wire next_enable = ctla_wr ? pwdata[`ADCRT_CTRLA_ENABLE] : converter_enable;
  wire next_start = (sw_start | auto_fire) & next_enable & ~busy;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev <= 1'b0;
      free_switch <= 1'b0;
    end else if (ce) begin
      trig_prev <= trig_now;
      free_switch <= wr & hit_trig & (wr_tsel == `ADCRT_TS_FREE)
                     & (trigger_source_select != `ADCRT_TS_FREE);
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 1'b0;
      auto_trigger_enable <= 1'b0;
      presc <= 3'h0;
      comparator_mux_steer <= 1'b0;
      trigger_source_select <= `ADCRT_TS_FREE;
      channel_select_reg <= `ADCRT_RST_BYTE;
      pin_input_disable_reg <= {NPIN{1'b0}};
      irq_mask <= `ADCRT_RST_IRQ;
    end else if (ce && wr) begin
      if (hit_ctla) begin
        converter_enable <= pwdata[`ADCRT_CTRLA_ENABLE];
        auto_trigger_enable <= pwdata[`ADCRT_CTRLA_AUTO];
        presc <= pwdata[`ADCRT_CTRLA_PRESC_LSB+2:`ADCRT_CTRLA_PRESC_LSB];
      end
      if (hit_trig) begin
        comparator_mux_steer <= pwdata[`ADCRT_TRIG_STEER];
        trigger_source_select <= wr_tsel;
      end
      if (hit_chan) begin
        channel_select_reg <= pwdata[7:0];
      end
      if (hit_pin) begin
        pin_input_disable_reg <= pwdata[NPIN-1:0];
      end
      if (hit_mask) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      conv_start <= next_start;
      if (!next_enable) begin
        busy <= 1'b0;
      end else if (next_start) begin
        busy <= 1'b1;
      end else if (conv_done) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Result pair and lock
  // ----------------------------------------
  wire lock_now = setup_rd & hit_low;
  wire unlock_now = setup_rd & hit_high;
  wire blocked = result_lock | lock_now;
  wire done_ok = conv_done & busy;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= `ADCRT_RST_RESULT;
      result_lock <= 1'b0;
    end else if (ce) begin
      if (done_ok && !blocked) begin
        result <= conv_result;
      end
      if (lock_now) begin
        result_lock <= 1'b1;
      end else if (unlock_now) begin
        result_lock <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Done flag and interrupt status
  // ----------------------------------------
  wire done_clr = ctla_wr & pwdata[`ADCRT_CTRLA_DONE];
  wire [2:0] ev = {done_ok & blocked, auto_fire & next_start, done_ok};
  wire [2:0] stat_clr = (wr & hit_stat) ? pwdata[2:0] : 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= 1'b0;
      irq_stat <= `ADCRT_RST_IRQ;
    end else if (ce) begin
      if (done_ok) begin
        conversion_done_flag <= 1'b1;
      end else if (done_clr) begin
        conversion_done_flag <= 1'b0;
      end
      irq_stat <= (irq_stat & ~stat_clr) | ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Analog steering and pins
  // ----------------------------------------
  assign comp_neg_from_mux = comparator_mux_steer & ~converter_enable;
  assign pin_digital_disable = pin_input_disable_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_read_value <= {NPIN{1'b0}};
    end else if (ce) begin
      pin_read_value <= pin_sync & ~pin_input_disable_reg;
    end
  end

  assign conv_enable = converter_enable;
  assign channel_select = channel_select_reg[`ADCRT_CHAN_MUX_LSB+3:`ADCRT_CHAN_MUX_LSB];
  assign reference_select = channel_select_reg[`ADCRT_CHAN_REF_LSB+1:`ADCRT_CHAN_REF_LSB];
  assign prescale_select = presc;

endmodule // adcrt_top

// ---- testbench.sv ----
// Purpose: Self-checking bench of the converter register block.
// Assumes: Zero wait-state APB slave.
// Notes: Byte address is four times the register index.
`timescale 1ns/1ns
module testbench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, q = 0;
  reg [6:0] trig_flags = 0;
  reg [7:0] pin_raw = 0;
  reg [9:0] value = 0;
  reg [3:0] dly = 4'h6;
  wire [31:0] prdata;
  wire [9:0] conv_result;
  wire [7:0] pin_digital_disable, pin_read_value;
  wire pready, pslverr, conv_enable, conv_start, conv_done, comp_neg_from_mux, irq;
  wire [3:0] channel_select;
  wire [1:0] reference_select;
  wire [2:0] prescale_select;
  integer n_errors = 0, comparisons = 0, k;
  always #25 pclk = ~pclk;
  adcrt_top DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_enable(conv_enable), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result), .channel_select(channel_select),
    .reference_select(reference_select), .prescale_select(prescale_select),
    .trig_flags(trig_flags),
    .comp_neg_from_mux(comp_neg_from_mux), .pin_digital_disable(pin_digital_disable),
    .pin_raw(pin_raw), .pin_read_value(pin_read_value), .irq(irq));
  adcrt_core_model core (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_enable(conv_enable), .dly(dly), .value(value), .conv_done(conv_done),
    .conv_result(conv_result));
  // ----
  // Tasks
  // ----
  task report_and_stop;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [7:0] idx, input w, input [7:0] d);
    integer i;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 20 && pready !== 1'b1; i = i + 1) @(posedge pclk);
      chk(pready, 1'b1);
      if (pready !== 1'b1) report_and_stop;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [7:0] idx, input [7:0] exp);
    begin
      apb(idx, 1'b0, 8'h00);
      chk(q, {24'h0, exp});
    end
  endtask
  task wait_done;
    integer j;
    begin
      q = 0;
      for (j = 0; j < 40 && q[4] !== 1'b1; j = j + 1) apb(8'h7a, 1'b0, 8'h00);
      if (q[4] !== 1'b1) chk(q, 32'h10);
      if (q[4] !== 1'b1) report_and_stop;
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors = n_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd(8'h7b, 8'h00);
    rd(8'h7e, 8'h00);
    rd(8'h7d, 8'h00);
    chk(e, 1'b1);
    apb(8'h78, 1'b1, 8'hff);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    value <= 10'h2b5;
    apb(8'h7a, 1'b1, 8'hc0);
    wait_done;
    rd(8'h78, 8'hb5);
    rd(8'h79, 8'h02);
    apb(8'h7c, 1'b1, 8'he5);
    chk(channel_select, 4'h5);
    chk(reference_select, 2'h3);
    rd(8'h79, 8'had);
    rd(8'h78, 8'h40);
    apb(8'h7c, 1'b1, 8'h00);
    value <= 10'h155;
    apb(8'h7a, 1'b1, 8'hd0);
    wait_done;
    rd(8'h79, 8'h02);
    rd(8'h78, 8'hb5);
    rd(8'h79, 8'h02);
    apb(8'h7a, 1'b1, 8'hd0);
    wait_done;
    rd(8'h78, 8'h55);
    rd(8'h79, 8'h01);
    apb(8'h71, 1'b1, 8'h01);
    chk(irq, 1'b1);
    apb(8'h70, 1'b1, 8'h07);
    chk(irq, 1'b0);
    dly <= 4'h1;
    apb(8'h7a, 1'b1, 8'hb0);
    apb(8'h7b, 1'b1, 8'h01);
    trig_flags <= 7'h01;
    wait_done;
    for (k = 2; k < 8; k = k + 1) begin
      trig_flags <= 7'h01 << (k - 1);
      apb(8'h7a, 1'b1, 8'hb0);
      apb(8'h7b, 1'b1, k[7:0]);
      wait_done;
    end
    trig_flags <= 7'h00;
    rd(8'h70, 8'h03);
    apb(8'h7b, 1'b1, 8'h00);
    rd(8'h7a, 8'hb0);
    rd(8'h7a, 8'hb0);
    dly <= 4'hf;
    apb(8'h7a, 1'b1, 8'hf0);
    wait_done;
    rd(8'h7a, 8'hf0);
    apb(8'h7b, 1'b1, 8'h01);
    trig_flags <= 7'h00;
    apb(8'h7a, 1'b1, 8'h90);
    wait_done;
    apb(8'h7a, 1'b1, 8'h90);
    trig_flags <= 7'h01;
    rd(8'h7a, 8'h80);
    rd(8'h7a, 8'h80);
    apb(8'h7a, 1'b1, 8'h00);
    apb(8'h7b, 1'b1, 8'h40);
    chk(comp_neg_from_mux, 1'b1);
    apb(8'h7a, 1'b1, 8'h86);
    chk(comp_neg_from_mux, 1'b0);
    chk(prescale_select, 3'h6);
    rd(8'h7b, 8'h40);
    pin_raw <= 8'hff;
    apb(8'h7e, 1'b1, 8'h0f);
    rd(8'h7e, 8'h0f);
    chk(pin_read_value, 8'hf0);
    report_and_stop;
  end
endmodule // testbench
bind adcrt_top adcrt_checker #(.AW(AW), .NPIN(NPIN)) u_chk (.*);
